//--- hdl/rtci_core.v
// Control register, periodic modulo-60 alarm and CPU interrupt of the real-time clock.
`timescale 1ns/10ps
// Notes on behaviour
// - Bit 14 gates the sticky write-sync status onto the CPU interrupt.
// - Bit 13 gates the sticky write-pending error status onto the CPU interrupt.
// - Bit 12 gates the sticky isolation status onto the CPU interrupt.
// - Bit 11 gates the sticky periodic alarm status onto the CPU interrupt.
// - Bits 10:5 set alarm units past each modulo-60 boundary.
// - Positions above 59 act exactly as position zero.
// - Writing the count word pair starts a new modulo-60 boundary.
// - Count enable rising from off starts a new boundary.
// - Prescale exponent change while counting starts a new boundary.
// - Bit 4 enables detection; the match is latched sticky until cleared.
// - Reduced instance reads isolation enable, periodic enable and position as zero.
`include "rtci_defs.vh"
module rtci_core #(
  parameter FULL_INSTANCE = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire unit_tick,
  input wire write_sync_event,
  input wire write_pending_event,
  input wire isolation_event,
  output reg cpu_irq,
  output reg count_enable,
  output reg [3:0] prescale_exponent,
  output reg [31:0] count_value
);
  localparam [15:0] KEEP = FULL_INSTANCE ? `RTCI_FULL_MASK : `RTCI_REDUCED_MASK;
  reg [15:0] ctrl_q;
  reg [15:0] aux_q;
  reg [15:0] cnt_lo_q;
  reg [15:0] cnt_hi_q;
  reg [15:0] lo_stage_q;
  reg lo_staged_q;
  reg [5:0] mod_q;
  reg [3:0] status_q;
  reg [15:0] ctrl_d;
  reg [15:0] aux_d;
  reg [15:0] lo_stage_d;
  reg lo_staged_d;
  reg [31:0] cnt_d;
  reg [5:0] mod_d;
  reg done_d;
  reg [3:0] status_d;
  reg done_q;
  wire [15:0] ctrl_eff;
  wire [5:0] pos_raw;
  wire [5:0] pos;
  wire [3:0] enables;
  wire [2:0] ev_rise;
  wire acc;
  wire wr;
  wire cnt_en_new;
  wire [3:0] pexp_new;
  wire pair_wr;
  wire boundary;
  wire alarm_hit;
  wire [3:0] set_bits;
  wire [3:0] clr_bits;
  wire [31:0] cnt_next;
  reg [15:0] rd_word;
  localparam EVENTS = 3;
  localparam [15:0] CTRL_RW = `RTCI_CTRL_RW;
  wire [EVENTS-1:0] ev_pin;
  wire ctrl_sel;
  wire aux_sel;
  wire lo_sel;
  wire hi_sel;
  wire step;
  wire bnd_enable;
  wire bnd_exp;
  wire [3:0] irq_src;

  // Fields missing in the reduced instance are dropped at the source so they never steer logic.
  assign ctrl_eff = ctrl_q & KEEP;
  assign pos_raw = ctrl_eff[`RTCI_POS_HI:`RTCI_POS_LO];
  assign pos = (pos_raw > `RTCI_POS_MAX) ? 6'h00 : pos_raw;
  assign enables = {ctrl_eff[`RTCI_BIT_PALM_EN], ctrl_eff[`RTCI_BIT_ISO_EN],
    ctrl_eff[`RTCI_BIT_WPND_EN], ctrl_eff[`RTCI_BIT_WSYNC_EN]};

  // One wait cycle per access keeps read data registered.
  assign acc = (avs_read | avs_write) & avs_waitrequest;
  assign wr = avs_write & avs_waitrequest;
  assign cnt_en_new = (wr && avs_address == `RTCI_OFS_AUX && avs_byteenable[0]) ?
    avs_writedata[`RTCI_BIT_CNT_EN] : aux_q[`RTCI_BIT_CNT_EN];
  assign pexp_new = (wr && avs_address == `RTCI_OFS_AUX && avs_byteenable[0]) ?
    avs_writedata[`RTCI_PEXP_HI:`RTCI_PEXP_LO] : aux_q[`RTCI_PEXP_HI:`RTCI_PEXP_LO];
  // The pair counts as written when the upper word lands after a lower-word write.
  assign ctrl_sel = wr && avs_address == `RTCI_OFS_CTRL;
  assign aux_sel = wr && avs_address == `RTCI_OFS_AUX;
  assign lo_sel = wr && avs_address == `RTCI_OFS_CNT_LO;
  assign hi_sel = wr && avs_address == `RTCI_OFS_CNT_HI;
  assign step = aux_q[`RTCI_BIT_CNT_EN] && unit_tick;
  assign pair_wr = hi_sel && lo_staged_q;
  assign bnd_enable = cnt_en_new && !aux_q[`RTCI_BIT_CNT_EN];
  // Only a real change of exponent counts; rewriting the same value keeps the phase.
  assign bnd_exp = aux_q[`RTCI_BIT_CNT_EN] && pexp_new != aux_q[`RTCI_PEXP_HI:`RTCI_PEXP_LO];
  assign boundary = pair_wr || bnd_enable || bnd_exp;
  assign irq_src = status_q & enables;
  // The match fires once per pass so a stalled tick cannot re-set the status after a clear.
  assign alarm_hit = ctrl_eff[`RTCI_BIT_PALM_ON] && mod_q == pos && !done_q && !boundary;
  assign ev_pin = {isolation_event, write_pending_event, write_sync_event};
  genvar g;
  generate
    for (g = 0; g < EVENTS; g = g + 1) begin : g_event
      reg meta_q;
      reg sync_q;
      reg prev_q;
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= ev_pin[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      // Edges are taken from the second stage only; the first may still be settling.
      assign ev_rise[g] = sync_q & ~prev_q;
    end
  endgenerate
  assign set_bits = {alarm_hit, ev_rise[2], ev_rise[1], ev_rise[0]};
  assign clr_bits = (wr && avs_address == `RTCI_OFS_STATUS && avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;
  assign cnt_next = {cnt_hi_q, cnt_lo_q} + 32'h0000_0001;

  always @* begin
    case (avs_address)
      `RTCI_OFS_CTRL: rd_word = ctrl_eff;
      `RTCI_OFS_CNT_LO: rd_word = cnt_lo_q;
      `RTCI_OFS_CNT_HI: rd_word = cnt_hi_q;
      `RTCI_OFS_AUX: rd_word = aux_q;
      `RTCI_OFS_STATUS: rd_word = {12'h000, status_q};
      `RTCI_OFS_EVENT: rd_word = {10'h000, mod_q};
      default: rd_word = 16'h0000;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(avs_read | avs_write) | !avs_waitrequest;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      if (acc && avs_read) begin
        avs_readdata <= {16'h0000, rd_word};
      end
    end
  end

  // The low nibble belongs to other functions of the clock and is never stored here.
  always @* begin
    ctrl_d = ctrl_q;
    if (ctrl_sel && avs_byteenable[0]) begin
      ctrl_d[7:0] = avs_writedata[7:0] & CTRL_RW[7:0];
    end
    if (ctrl_sel && avs_byteenable[1]) begin
      ctrl_d[15:8] = avs_writedata[15:8];
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `RTCI_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always @* begin
    aux_d = aux_q;
    if (aux_sel && avs_byteenable[0]) begin
      aux_d[7:0] = avs_writedata[7:0];
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_q <= `RTCI_AUX_RST;
    end else begin
      aux_q <= aux_d;
    end
  end

  // The lower word waits here so both halves land in one cycle and the count is never torn.
  always @* begin
    lo_stage_d = lo_stage_q;
    lo_staged_d = lo_staged_q;
    if (lo_sel) begin
      lo_stage_d = avs_writedata[15:0];
      lo_staged_d = 1'b1;
    end else if (pair_wr) begin
      lo_staged_d = 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo_stage_q <= 16'h0000;
      lo_staged_q <= 1'b0;
    end else begin
      lo_stage_q <= lo_stage_d;
      lo_staged_q <= lo_staged_d;
    end
  end

  always @* begin
    cnt_d = {cnt_hi_q, cnt_lo_q};
    if (pair_wr) begin
      cnt_d = {avs_writedata[15:0], lo_stage_q};
    end else if (step) begin
      cnt_d = cnt_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_lo_q <= 16'h0000;
      cnt_hi_q <= 16'h0000;
    end else begin
      cnt_lo_q <= cnt_d[15:0];
      cnt_hi_q <= cnt_d[31:16];
    end
  end

  // The phase restarts on every boundary, so the alarm repeats each sixty units from there.
  always @* begin
    mod_d = mod_q;
    done_d = done_q;
    if (boundary) begin
      mod_d = 6'h00;
      done_d = 1'b0;
    end else if (step) begin
      mod_d = (mod_q == `RTCI_MOD_LAST) ? 6'h00 : mod_q + 6'h01;
      done_d = 1'b0;
    end else if (alarm_hit) begin
      done_d = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mod_q <= 6'h00;
      done_q <= 1'b0;
    end else begin
      mod_q <= mod_d;
      done_q <= done_d;
    end
  end

  // A new event in the clearing cycle survives the clear.
  always @* begin
    status_d = (status_q & ~clr_bits) | set_bits;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 4'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // The interrupt is registered so it cannot glitch while status and enables change together.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= |irq_src;
    end
  end

  // The link outputs are registered copies, so the rest of the clock sees them one cycle late.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_enable <= 1'b0;
      prescale_exponent <= 4'h0;
      count_value <= 32'h0000_0000;
    end else begin
      count_enable <= aux_q[`RTCI_BIT_CNT_EN];
      prescale_exponent <= aux_q[`RTCI_PEXP_HI:`RTCI_PEXP_LO];
      count_value <= {cnt_hi_q, cnt_lo_q};
    end
  end
endmodule

//--- hdl/rtci_defs.vh
// Register map, field positions and reset values of the clock interrupt and periodic alarm block.
`ifndef RTCI_DEFS_VH
`define RTCI_DEFS_VH
`define RTCI_ADDR_W 4
`define RTCI_OFS_CTRL 4'h0
`define RTCI_OFS_CNT_LO 4'h1
`define RTCI_OFS_CNT_HI 4'h2
`define RTCI_OFS_AUX 4'h3
`define RTCI_OFS_STATUS 4'h4
`define RTCI_OFS_EVENT 4'h5
`define RTCI_BIT_WSYNC_EN 14
`define RTCI_BIT_WPND_EN 13
`define RTCI_BIT_ISO_EN 12
`define RTCI_BIT_PALM_EN 11
`define RTCI_POS_HI 10
`define RTCI_POS_LO 5
`define RTCI_BIT_PALM_ON 4
`define RTCI_BIT_CNT_EN 0
`define RTCI_PEXP_HI 4
`define RTCI_PEXP_LO 1
`define RTCI_ST_WSYNC 0
`define RTCI_ST_WPND 1
`define RTCI_ST_ISO 2
`define RTCI_ST_PALM 3
`define RTCI_CTRL_RST 16'h0000
`define RTCI_AUX_RST 16'h0000
`define RTCI_POS_MAX 6'h3b
`define RTCI_MOD_LAST 6'h3b
`define RTCI_FULL_MASK 16'hffff
`define RTCI_REDUCED_MASK 16'he010
`define RTCI_CTRL_RW 16'hfff0
`endif

//--- verif/rtci_core_sva.sv
// Port assertions of the clock interrupt block.
`timescale 1ns/10ps
module rtci_sva (
  input wire clk_sys,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire cpu_irq,
  input wire count_enable,
  input wire [3:0] avs_address,
  input wire [3:0] prescale_exponent,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata
);
  reg [3:0] en_q;
  wire tk = (avs_read | avs_write) & avs_waitrequest;
  wire an = avs_read & !avs_waitrequest;
  wire ax = tk & avs_write & avs_address == 4'h3;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) en_q <= 4'h0;
    else if (tk & avs_write & avs_address == 4'h0) en_q <= avs_writedata[14:11];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_wait_one: assert property (tk |=> !avs_waitrequest) else $error("no answer");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  a_upper_zero: assert property (an |-> avs_readdata[31:16] == 16'h0) else $error("upper");
  a_ctrl_low: assert property (an && avs_address == 4'h0 |-> avs_readdata[3:0] == 4'h0) else $error("low");
  a_unmapped_zero: assert property (an && avs_address > 4'h5 |-> avs_readdata == 32'h0) else $error("map");
  a_enable_copy: assert property (ax |-> ##2 count_enable == $past(avs_writedata[0], 2)) else $error("en");
  a_exp_copy: assert property (ax |-> ##2 prescale_exponent == $past(avs_writedata[4:1], 2)) else $error("exp");
  a_irq_masked: assert property ((en_q == 4'h0) [*2] |-> !cpu_irq) else $error("irq");
  c_mod_read: cover property (an && avs_address == 4'h5);
  c_irq: cover property ($rose(cpu_irq));
  c_enable: cover property ($rose(count_enable));
endmodule
bind rtci_core rtci_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cpu_irq(cpu_irq), .count_enable(count_enable), .avs_address(avs_address),
  .prescale_exponent(prescale_exponent), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata));

//--- verif/tb.sv
// Bus-level bench of the clock interrupt block.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; $display("unexpected %s %h %h", n, e, s); end end
module tb;
  logic clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, unit_tick = 0;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [2:0] ev = 0;
  logic [15:0] d;
  wire [31:0] avs_readdata, count_value, red_readdata;
  wire [3:0] prescale_exponent;
  wire avs_waitrequest, cpu_irq, count_enable;
  int err_count = 0, n_compared = 0, i;
  always #4 clk_sys = ~clk_sys;
  rtci_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .unit_tick(unit_tick), .write_sync_event(ev[0]),
    .write_pending_event(ev[1]), .isolation_event(ev[2]), .cpu_irq(cpu_irq), .count_enable(count_enable),
    .prescale_exponent(prescale_exponent), .count_value(count_value));
  rtci_core #(.FULL_INSTANCE(0)) uut_reduced (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(red_readdata), .avs_waitrequest(), .unit_tick(unit_tick), .write_sync_event(ev[0]),
    .write_pending_event(ev[1]), .isolation_event(ev[2]), .cpu_irq(), .count_enable(),
    .prescale_exponent(), .count_value());
  task automatic bus(bit w, bit [3:0] a, bit [15:0] v);
    @(posedge clk_sys);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, 16'h0000, v};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[15:0];
    {avs_write, avs_read} <= 2'b00;
  endtask
  task automatic tick(int n);
    repeat (2 * n) @(posedge clk_sys) unit_tick <= !unit_tick;
  endtask
  // The phase is stepped off zero before the clear, so a match at the boundary cannot leak in.
  task automatic alarm(bit [5:0] p, int n);
    bus(1, 4'h0, {5'h01, p, 5'h10});
    bus(1, 4'h1, 0);
    bus(1, 4'h2, 0);
    tick(1);
    bus(1, 4'h4, 16'h000f);
    tick(n - 2);
    bus(0, 4'h4, 0);
    `CHK("early", 16'h0000, d)
    tick(1);
    bus(0, 4'h4, 0);
    `CHK("alarm", 16'h0008, d)
    `CHK("irq", 1'b1, cpu_irq)
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(0, 4'h0, 0);
    `CHK("reset", 16'h0000, d)
    bus(1, 4'h0, 16'hffff);
    bus(0, 4'h0, 0);
    `CHK("ctrl", 16'hfff0, d)
    `CHK("reduced", 16'he010, red_readdata[15:0])
    bus(1, 4'h9, 16'hffff);
    bus(0, 4'h9, 0);
    `CHK("unmapped", 16'h0000, d)
    bus(1, 4'h0, 0);
    $display("registers done");
    for (i = 0; i < 3; i++) begin
      ev <= 3'b001 << i;
      repeat (8) @(posedge clk_sys);
      `CHK("masked", 1'b0, cpu_irq)
      bus(1, 4'h0, 16'h4000 >> i);
      repeat (2) @(posedge clk_sys);
      `CHK("irq", 1'b1, cpu_irq)
      ev <= 3'b000;
      bus(1, 4'h4, 16'h0001 << i);
      repeat (2) @(posedge clk_sys);
      `CHK("cleared", 1'b0, cpu_irq)
    end
    $display("interrupts done");
    bus(1, 4'h3, 16'h0001);
    for (i = 0; i < 3; i++) begin
      tick(5);
      bus(0, 4'h5, 0);
      `CHK("phase", 16'h0005, d)
      case (i)
        0: begin bus(1, 4'h1, 16'h1234); bus(1, 4'h2, 16'h5678); end
        1: begin bus(1, 4'h3, 0); bus(1, 4'h3, 1); end
        default: bus(1, 4'h3, 16'h0003);
      endcase
      bus(0, 4'h5, 0);
      `CHK("boundary", 16'h0000, d)
    end
    `CHK("count", 32'h5678123e, count_value)
    $display("boundaries done");
    alarm(6'h03, 3);
    alarm(6'h3f, 60);
    $display("alarm done");
    conclude;
  end
endmodule
